/* File: core/mlb_diag.sv */
// Purpose: Loopback diagnostics controller and result-code reporter
// Assumes: All inputs come from logic on sys_clk
// Notes: Two-entry buffers sit in both character paths
`timescale 1ns/1ps

module mlb_buf2 #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic nxt_room,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [1:0] cnt_ff, nxt_cnt;
  logic [W-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
  logic rdy_ff, vld_ff, nxt_vld;
  logic push, pop;

  always_comb begin
    push = in_valid & rdy_ff;
    pop = (cnt_ff != 2'd0) & out_ready;
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    nxt_head = pop ? tail_ff : head_ff;
    nxt_tail = tail_ff;
    if (push) begin
      if (cnt_ff == 2'd0 || (cnt_ff == 2'd1 && pop)) begin
        nxt_head = in_data;
      end else begin
        nxt_tail = in_data;
      end
    end
    nxt_room = nxt_cnt != 2'd2;
    nxt_vld = nxt_cnt != 2'h0;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 2'd0;
      head_ff <= '0;
      tail_ff <= '0;
      rdy_ff <= 1'b1;
      vld_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      rdy_ff <= nxt_room;
      vld_ff <= nxt_vld;
    end
  end

  assign in_ready = rdy_ff;
  assign out_valid = vld_ff;
  assign out_data = head_ff;
endmodule

module mlb_diag #(
  parameter int TICK_CYCLES = mlb_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire mlb_pkg::mlb_cmd_t cmd,
  input wire logic dur_wr,
  input wire logic [7:0] dur_wdata,
  output logic [7:0] test_duration_seconds,
  input wire mlb_pkg::mlb_link_t link,
  input wire logic rmt_req_valid,
  input wire logic call_evt_valid,
  input wire logic [3:0] call_evt_code,
  input wire logic [2:0] cp_sel,
  input wire logic conn_evt_valid,
  input wire logic report_mod,
  input wire logic host_tx_valid,
  input wire logic [7:0] host_tx_data,
  output logic host_tx_ready,
  output logic host_rx_valid,
  output logic [7:0] host_rx_data,
  input wire logic host_rx_ready,
  input wire logic line_rx_valid,
  input wire logic [7:0] line_rx_data,
  output logic line_rx_ready,
  output logic line_tx_valid,
  output logic [7:0] line_tx_data,
  input wire logic line_tx_ready,
  output logic res_valid,
  output logic [3:0] res_code,
  output logic conn_valid,
  output mlb_pkg::mlb_conn_t conn_rpt,
  output logic drop_line,
  output logic test_active
);
  import mlb_pkg::*;

  mlb_state_t state_ff, nxt_state;
  logic [7:0] dur_ff, nxt_dur, secs_ff, nxt_secs, gen_ff, nxt_gen, exp_ff, nxt_exp;
  logic [31:0] div_ff, nxt_div;
  logic [11:0] err_ff, nxt_err;
  logic [1:0] dig_ff, nxt_dig;
  logic accept_ff, nxt_accept, host_rdy_ff, nxt_host_rdy, line_rdy_ff, nxt_line_rdy;
  logic res_valid_ff, nxt_res_valid, conn_valid_ff, nxt_conn_valid, drop_ff, nxt_drop;
  logic [3:0] res_code_ff, nxt_res_code;
  mlb_conn_t conn_ff, nxt_conn;
  logic lf_in_valid, lf_in_ready, lf_room, hf_in_valid, hf_in_ready, hf_room;
  logic [7:0] lf_in_data, hf_in_data;
  logic host_take, line_take, running, allowed, tick, do_end, do_enter, active_ff, nxt_active;

  function automatic logic [11:0] bcd_inc(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (v != 12'h999) begin
      if (v[3:0] != 4'h9) begin
        r[3:0] = v[3:0] + 4'h1;
      end else if (v[7:4] != 4'h9) begin
        r[7:0] = {v[7:4] + 4'h1, 4'h0};
      end else begin
        r = {v[11:8] + 4'h1, 8'h00};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  mlb_buf2 #(.W(8)) u_line_buf (
    .sys_clk(sys_clk), .nrst(nrst), .in_valid(lf_in_valid), .in_data(lf_in_data),
    .in_ready(lf_in_ready), .nxt_room(lf_room), .out_valid(line_tx_valid),
    .out_data(line_tx_data), .out_ready(line_tx_ready)
  );

  mlb_buf2 #(.W(8)) u_host_buf (
    .sys_clk(sys_clk), .nrst(nrst), .in_valid(hf_in_valid), .in_data(hf_in_data),
    .in_ready(hf_in_ready), .nxt_room(hf_room), .out_valid(host_rx_valid),
    .out_data(host_rx_data), .out_ready(host_rx_ready)
  );

  always_comb begin
    running = state_ff inside {ST_RLOOP, ST_RLOOP_ST, ST_LLOOP, ST_ECHO};
    allowed = link.up & link.normal_mode & (link.speed_idx >= SPD_1200) &
              !(link.modul inside {MOD_B103, MOD_V21, MOD_V23});
    tick = div_ff == 32'(TICK_CYCLES - 1);
    host_take = host_tx_valid & host_rdy_ff;
    line_take = line_rx_valid & line_rdy_ff;
    nxt_state = state_ff;
    nxt_dur = dur_wr ? dur_wdata : dur_ff;
    nxt_secs = (running && tick) ? secs_ff + 8'h01 : secs_ff;
    nxt_div = running ? (tick ? 32'd0 : div_ff + 32'd1) : 32'd0;
    nxt_gen = gen_ff;
    nxt_exp = exp_ff;
    nxt_err = err_ff;
    nxt_dig = dig_ff;
    nxt_accept = accept_ff;
    nxt_res_valid = 1'b0;
    nxt_res_code = res_code_ff;
    nxt_conn_valid = 1'b0;
    nxt_conn = conn_ff;
    nxt_drop = 1'b0;
    lf_in_valid = 1'b0;
    lf_in_data = (state_ff inside {ST_LLOOP, ST_ECHO}) ? line_rx_data : host_tx_data;
    hf_in_valid = 1'b0;
    hf_in_data = line_rx_data;
    do_end = 1'b0;
    do_enter = 1'b0;
    case (state_ff)
      ST_IDLE, ST_RLOOP: begin
        lf_in_valid = host_take;
        hf_in_valid = line_take;
      end
      ST_RLOOP_ST: begin
        lf_in_valid = 1'b1;
        lf_in_data = gen_ff;
        nxt_gen = lf_in_ready ? lfsr_step(gen_ff) : gen_ff;
        if (line_take) begin
          nxt_exp = lfsr_step(exp_ff);
          nxt_err = (line_rx_data != exp_ff) ? bcd_inc(err_ff) : err_ff;
        end
      end
      ST_LLOOP, ST_ECHO: lf_in_valid = line_take;
      ST_RPT: begin
        hf_in_valid = 1'b1;
        hf_in_data = ASCII_ZERO | {4'h0, err_ff[4*(2-dig_ff) +: 4]};
        if (hf_in_ready) begin
          nxt_dig = dig_ff + 2'd1;
          if (dig_ff == 2'd2) begin
            nxt_state = ST_IDLE;
            nxt_res_valid = 1'b1;
            nxt_res_code = RC_OK;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (cmd_valid && state_ff != ST_RPT) begin
      nxt_res_valid = 1'b1;
      nxt_res_code = RC_OK;
      case (cmd)
        CMD_REMOTE_ST, CMD_REMOTE, CMD_LOCAL: begin
          if (state_ff == ST_IDLE && allowed) begin
            do_enter = 1'b1;
            nxt_state = cmd == CMD_REMOTE_ST ? ST_RLOOP_ST :
                        cmd == CMD_REMOTE ? ST_RLOOP : ST_LLOOP;
          end else begin
            nxt_res_code = RC_ERROR;
          end
        end
        CMD_ACCEPT: nxt_accept = 1'b1;
        CMD_IGNORE: nxt_accept = 1'b0;
        CMD_END: do_end = running;
        CMD_HANGUP: begin
          do_end = running;
          nxt_drop = 1'b1;
        end
        default: nxt_res_valid = 1'b0;
      endcase
    end else if (running && dur_ff != DUR_RST && secs_ff == dur_ff) begin
      do_end = 1'b1;
    end else if (state_ff == ST_IDLE && rmt_req_valid && accept_ff && allowed) begin
      do_enter = 1'b1;
      nxt_state = ST_ECHO;
    end else if (call_evt_valid && state_ff != ST_RPT) begin
      nxt_res_valid = 1'b1;
      nxt_res_code = (cp_sel == 3'h0 && call_evt_code inside {[RC_NO_PROMPT:RC_NO_ANSWER]}) ?
                     RC_NO_CARRIER : call_evt_code;
    end
    if (do_end) begin
      nxt_secs = 8'd0;
      nxt_state = state_ff == ST_RLOOP_ST ? ST_RPT : ST_IDLE;
      nxt_dig = 2'h0;
      nxt_res_valid = nxt_res_valid & (state_ff != ST_RLOOP_ST);
    end
    if (do_enter) begin
      nxt_secs = 8'h00;
      nxt_gen = LFSR_SEED;
      nxt_exp = LFSR_SEED;
      nxt_err = 12'h000;
    end
    if (conn_evt_valid) begin
      nxt_conn_valid = 1'b1;
      nxt_conn.speed_idx = link.speed_idx;
      nxt_conn.rel_sfx = link.reliable;
      nxt_conn.tag = TAG_SPEED;
      if (report_mod) begin
        if (link.modul inside {MOD_V21, MOD_B103} && link.speed_idx == SPD_300) begin
          nxt_conn.tag = !link.reliable ? TAG_NONE :
                         link.modul == MOD_V21 ? TAG_V21 : TAG_B103;
        end else if (link.modul == MOD_V23) begin
          nxt_conn.tag = link.reliable ? TAG_NONE : TAG_V23_HDX;
          nxt_conn.rel_sfx = 1'b0;
        end
      end
    end
    nxt_host_rdy = (nxt_state == ST_IDLE || nxt_state == ST_RLOOP) & lf_room;
    nxt_active = nxt_state inside {ST_RLOOP, ST_RLOOP_ST, ST_LLOOP, ST_ECHO};
    case (nxt_state)
      ST_IDLE, ST_RLOOP: nxt_line_rdy = hf_room;
      ST_LLOOP, ST_ECHO: nxt_line_rdy = lf_room;
      ST_RLOOP_ST: nxt_line_rdy = 1'b1;
      default: nxt_line_rdy = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      dur_ff <= DUR_RST;
      secs_ff <= 8'd0;
      div_ff <= 32'd0;
      gen_ff <= LFSR_SEED;
      exp_ff <= LFSR_SEED;
      err_ff <= 12'h000;
      dig_ff <= 2'd0;
      accept_ff <= 1'b0;
      host_rdy_ff <= 1'b0;
      line_rdy_ff <= 1'b0;
      res_valid_ff <= 1'b0;
      res_code_ff <= RC_OK;
      conn_valid_ff <= 1'b0;
      conn_ff <= '0;
      drop_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dur_ff <= nxt_dur;
      secs_ff <= nxt_secs;
      div_ff <= nxt_div;
      gen_ff <= nxt_gen;
      exp_ff <= nxt_exp;
      err_ff <= nxt_err;
      dig_ff <= nxt_dig;
      accept_ff <= nxt_accept;
      host_rdy_ff <= nxt_host_rdy;
      line_rdy_ff <= nxt_line_rdy;
      res_valid_ff <= nxt_res_valid;
      res_code_ff <= nxt_res_code;
      conn_valid_ff <= nxt_conn_valid;
      conn_ff <= nxt_conn;
      drop_ff <= nxt_drop;
      active_ff <= nxt_active;
    end
  end

  assign test_duration_seconds = dur_ff;
  assign host_tx_ready = host_rdy_ff;
  assign line_rx_ready = line_rdy_ff;
  assign res_valid = res_valid_ff;
  assign res_code = res_code_ff;
  assign conn_valid = conn_valid_ff;
  assign conn_rpt = conn_ff;
  assign drop_line = drop_ff;
  assign test_active = active_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_hangup_drop;
    cmd_valid && cmd == CMD_HANGUP && state_ff != ST_RPT |=> drop_line && !running;
  endproperty
  a_hangup_drop: assert property (p_hangup_drop) else $error("hang-up did not end");
  property p_timeout;
    running && dur_ff != 8'd0 && secs_ff == dur_ff && !cmd_valid |=> !running;
  endproperty
  a_timeout: assert property (p_timeout) else $error("test not ended at timeout");
  property p_no_timeout;
    state_ff == ST_LLOOP && dur_ff == 8'd0 && !cmd_valid |=> state_ff == ST_LLOOP;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("local loop ended alone");
  property p_lloop_hidden;
    state_ff == ST_LLOOP |-> !hf_in_valid;
  endproperty
  a_lloop_hidden: assert property (p_lloop_hidden) else $error("loop data to host");
  property p_report;
    state_ff == ST_RLOOP_ST ##1 state_ff == ST_RPT |-> ##[1:300] res_valid && res_code == 4'h0;
  endproperty
  a_report: assert property (p_report) else $error("no OK after error count");
  property p_ignore;
    !accept_ff && state_ff == ST_IDLE && !cmd_valid |=> state_ff != ST_ECHO;
  endproperty
  a_ignore: assert property (p_ignore) else $error("remote request honoured");
  property p_accept;
    accept_ff && allowed && rmt_req_valid && state_ff == ST_IDLE && !cmd_valid
      |=> state_ff == ST_ECHO;
  endproperty
  a_accept: assert property (p_accept) else $error("remote request refused");
  property p_refuse;
    cmd_valid && cmd == CMD_LOCAL && state_ff == ST_IDLE && !allowed
      |=> res_valid && res_code == 4'h4 && state_ff == ST_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("loop not refused");
  property p_timer_clear;
    running ##1 !running |-> secs_ff == 8'd0;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("seconds not cleared");
  property p_cp_mask;
    call_evt_valid && !cmd_valid && state_ff == ST_IDLE && !rmt_req_valid && cp_sel == 3'd0
      && call_evt_code == 4'h7 |=> res_code == 4'h3;
  endproperty
  a_cp_mask: assert property (p_cp_mask) else $error("busy not masked");
endmodule

/* File: shared/mlb_pkg.sv */
// Purpose: Shared types and constants for the modem loopback diagnostics block
// Assumes: One 200 MHz clock, command decoding done upstream
// Notes: Summary of operation follows
//
// Summary of operation
// - Self-test remote loop sends a pattern and checks the echoed pattern.
// - Self-test end reports three decimal error digits, then OK; silent while running.
// - Timer expiry or end command ends a test; hang-up also drops the line.
// - Remote loop forwards host characters to line and echoes back unchanged.
// - Local loop returns line characters to the line, never to the host.
// - Without timer, local loop runs until command or hang-up stops it.
// - After accept, a remote loop request from the remote modem is honoured.
// - After ignore, remote loop requests from the remote modem are disregarded.
// - Duration resets to zero; zero disables automatic timeout.
// - Duration 1 to 255 ends any test after that many seconds.
// - General result codes: OK 0 up to NO ANSWER 8.
// - Call-progress codes depend on the call-progress selection setting.
// - Host speed report shows bare speed, or speed with REL when reliable.
// - Modulation report: REL forms, V.21/103 REL at 300, V.23 HDX non-reliable.
// - Loops refused on Bell 103, V.21, V.23, below 1200 bps, or wrong mode.
package mlb_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYC = TICK_TIME_S * CLK_HZ;
  localparam logic [7:0] DUR_RST = 8'h00;
  localparam logic [7:0] LFSR_SEED = 8'h5A;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [4:0] SPD_300 = 5'h01;
  localparam logic [4:0] SPD_1200 = 5'h03;
  localparam logic [3:0] RC_OK = 4'h0;
  localparam logic [3:0] RC_CONNECT = 4'h1;
  localparam logic [3:0] RC_RING = 4'h2;
  localparam logic [3:0] RC_NO_CARRIER = 4'h3;
  localparam logic [3:0] RC_ERROR = 4'h4;
  localparam logic [3:0] RC_NO_PROMPT = 4'h5;
  localparam logic [3:0] RC_NO_DIALTONE = 4'h6;
  localparam logic [3:0] RC_BUSY = 4'h7;
  localparam logic [3:0] RC_NO_ANSWER = 4'h8;
  typedef enum logic [2:0] {
    CMD_REMOTE_ST = 3'b000, CMD_REMOTE = 3'b001, CMD_LOCAL = 3'b010, CMD_ACCEPT = 3'b011,
    CMD_IGNORE = 3'b100, CMD_END = 3'b101, CMD_HANGUP = 3'b110, CMD_NONE = 3'b111
  } mlb_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RLOOP = 3'b001, ST_RLOOP_ST = 3'b010, ST_LLOOP = 3'b011,
    ST_ECHO = 3'b100, ST_RPT = 3'b101
  } mlb_state_t;
  typedef enum logic [2:0] {
    MOD_V21 = 3'b000, MOD_B103 = 3'b001, MOD_V23 = 3'b010, MOD_V22 = 3'b011,
    MOD_V32 = 3'b100, MOD_V34 = 3'b101, MOD_OTHER = 3'b110
  } mlb_mod_t;
  typedef enum logic [2:0] {
    TAG_NONE = 3'b000, TAG_SPEED = 3'b001, TAG_V21 = 3'b010, TAG_B103 = 3'b011,
    TAG_V23_HDX = 3'b100
  } mlb_tag_t;
  typedef struct packed {
    logic up;
    logic normal_mode;
    logic reliable;
    mlb_mod_t modul;
    logic [4:0] speed_idx;
  } mlb_link_t;
  typedef struct packed {
    logic [4:0] speed_idx;
    logic rel_sfx;
    mlb_tag_t tag;
  } mlb_conn_t;
endpackage

/* File: test/mlb_diag_tb.sv */
// Purpose: Self-checking bench for the loopback diagnostics block
// Assumes: Short seconds tick for simulation
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps

module mlb_diag_tb;
  import mlb_pkg::*;
  localparam int TK = 20;
  localparam mlb_link_t OK_LINK = {1'b1, 1'b1, 1'b0, MOD_V32, 5'h05};
  logic sys_clk, nrst, cmd_valid, dur_wr, rmt_req_valid, call_evt_valid, conn_evt_valid;
  logic report_mod, host_tx_valid, host_rx_ready, line_rx_valid, line_rx_ready, line_tx_valid;
  logic line_tx_ready, host_tx_ready, host_rx_valid, res_valid, conn_valid, drop_line;
  logic test_active, echo_en, stall, corrupt;
  logic [7:0] dur_wdata, test_duration_seconds, host_tx_data, host_rx_data;
  logic [7:0] line_rx_data, line_tx_data;
  logic [3:0] call_evt_code, res_code;
  logic [2:0] cp_sel;
  mlb_cmd_t cmd;
  mlb_link_t link;
  mlb_conn_t conn_rpt;
  int errors, n_tests, drops;
  logic [7:0] hq[$];

  mlb_diag #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd(cmd), .dur_wr(dur_wr), .dur_wdata(dur_wdata),
    .test_duration_seconds(test_duration_seconds), .link(link), .rmt_req_valid(rmt_req_valid),
    .call_evt_valid(call_evt_valid), .call_evt_code(call_evt_code), .cp_sel(cp_sel),
    .conn_evt_valid(conn_evt_valid), .report_mod(report_mod), .host_tx_valid(host_tx_valid),
    .host_tx_data(host_tx_data), .host_tx_ready(host_tx_ready), .host_rx_valid(host_rx_valid),
    .host_rx_data(host_rx_data), .host_rx_ready(host_rx_ready), .line_rx_valid(line_rx_valid),
    .line_rx_data(line_rx_data), .line_rx_ready(line_rx_ready), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready), .res_valid(res_valid),
    .res_code(res_code), .conn_valid(conn_valid), .conn_rpt(conn_rpt), .drop_line(drop_line),
    .test_active(test_active));
  mlb_remote_model i_rem (.sys_clk(sys_clk), .nrst(nrst), .echo_en(echo_en), .stall(stall),
    .corrupt(corrupt), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
    .line_tx_ready(line_tx_ready), .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data),
    .line_rx_ready(line_rx_ready));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (host_rx_valid === 1'b1 && host_rx_ready === 1'b1) hq.push_back(host_rx_data);
    if (drop_line === 1'b1) drops++;
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_res(input logic [3:0] code);
    int i;
    i = 0;
    while (res_valid !== 1'b1 && i < 20) begin
      cyc(1);
      i++;
    end
    chk(res_valid === 1'b1 && res_code === code, "result code");
    cyc(1);
  endtask
  task automatic give_cmd(input mlb_cmd_t c, input logic [3:0] code);
    cmd_valid = 1'b1;
    cmd = c;
    cyc(1);
    cmd_valid = 1'b0;
    wait_res(code);
  endtask
  task automatic set_dur(input logic [7:0] v);
    dur_wdata = v;
    dur_wr = 1'b1;
    cyc(1);
    dur_wr = 1'b0;
    cyc(1);
    chk(test_duration_seconds === v, "duration readback");
  endtask
  task automatic host_send(input logic [7:0] d);
    logic ok;
    int i;
    host_tx_valid = 1'b1;
    host_tx_data = d;
    i = 0;
    do begin
      @(posedge sys_clk);
      ok = host_tx_ready;
      @(negedge sys_clk);
      i++;
    end while (ok !== 1'b1 && i < 50);
  endtask

  task automatic t_refuse();
    for (int k = 0; k < 5; k++) begin
      link = OK_LINK;
      if (k < 3) link.modul = mlb_mod_t'(k);
      if (k == 3) link.speed_idx = 5'h02;
      if (k == 4) link.normal_mode = 1'b0;
      give_cmd(CMD_LOCAL, RC_ERROR);
      chk(test_active === 1'b0, "loop refused");
    end
    link = OK_LINK;
  endtask
  task automatic t_local();
    hq.delete();
    i_rem.seen.delete();
    echo_en = 1'b0;
    give_cmd(CMD_LOCAL, RC_OK);
    stall = 1'b1;
    for (int i = 0; i < 5; i++) i_rem.send(8'h41 + 8'(i));
    cyc(12);
    chk(line_rx_ready === 1'b0, "full buffer refuses");
    stall = 1'b0;
    cyc(6 * TK);
    chk(i_rem.seen.size() == 5 && hq.size() == 0, "local loop count");
    for (int i = 0; i < 5; i++) chk(i_rem.seen[i] === 8'h41 + 8'(i), "local data");
    chk(test_active === 1'b1, "loop keeps running");
    give_cmd(CMD_END, RC_OK);
    chk(test_active === 1'b0, "loop ended");
  endtask
  task automatic t_remote();
    hq.delete();
    echo_en = 1'b1;
    host_rx_ready = 1'b0;
    give_cmd(CMD_REMOTE, RC_OK);
    for (int i = 0; i < 4; i++) host_send(8'hc0 + 8'(i));
    host_tx_valid = 1'b0;
    host_rx_ready = 1'b1;
    cyc(20);
    chk(hq.size() == 4, "echo count");
    for (int i = 0; i < 4; i++) chk(hq[i] === 8'hc0 + 8'(i), "echo data");
    give_cmd(CMD_END, RC_OK);
  endtask
  task automatic t_self();
    set_dur(8'h02);
    for (int k = 0; k < 2; k++) begin
      hq.delete();
      i_rem.seen.delete();
      corrupt = k[0];
      echo_en = 1'b1;
      // Link is up and host is back in command state
      link = OK_LINK;
      give_cmd(CMD_REMOTE_ST, RC_OK);
      cyc(2 * TK - 4);
      chk(test_active === 1'b1 && hq.size() == 0, "silent run");
      stall = 1'b1;
      wait_res(RC_OK);
      chk(test_active === 1'b0 && hq.size() == 3, "three digits");
      chk(i_rem.seen[0] === LFSR_SEED, "pattern start");
      if (k == 0) chk({hq[0], hq[1], hq[2]} === "000", "no errors");
      else chk({hq[0], hq[1], hq[2]} !== "000", "errors seen");
      echo_en = 1'b0;
      stall = 1'b0;
      cyc(10);
    end
    set_dur(8'h00);
  endtask
  task automatic t_rmt_req();
    give_cmd(CMD_IGNORE, RC_OK);
    rmt_req_valid = 1'b1;
    cyc(1);
    rmt_req_valid = 1'b0;
    cyc(3);
    chk(test_active === 1'b0, "request ignored");
    give_cmd(CMD_ACCEPT, RC_OK);
    rmt_req_valid = 1'b1;
    cyc(1);
    rmt_req_valid = 1'b0;
    cyc(3);
    chk(test_active === 1'b1, "request honoured");
    i_rem.seen.delete();
    i_rem.send(8'h77);
    cyc(10);
    chk(i_rem.seen.size() == 1 && i_rem.seen[0] === 8'h77, "remote echo");
    drops = 0;
    give_cmd(CMD_HANGUP, RC_OK);
    chk(drops == 1 && test_active === 1'b0, "hang-up drops line");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 18; c++) begin
      cp_sel = (c < 9) ? 3'h1 : 3'h0;
      call_evt_code = 4'(c % 9);
      call_evt_valid = 1'b1;
      cyc(1);
      call_evt_valid = 1'b0;
      wait_res((c >= 14) ? RC_NO_CARRIER : 4'(c % 9));
    end
  endtask
  task automatic t_conn();
    mlb_mod_t md[8] = '{MOD_V32, MOD_V32, MOD_V21, MOD_B103, MOD_V21, MOD_V23, MOD_V23, MOD_V34};
    mlb_tag_t tg[8] = '{TAG_SPEED, TAG_SPEED, TAG_V21, TAG_B103, TAG_NONE, TAG_V23_HDX,
      TAG_NONE, TAG_SPEED};
    logic [7:0] rm = 8'hfc;
    logic [7:0] rl = 8'hce;
    for (int i = 0; i < 8; i++) begin
      link.modul = md[i];
      link.speed_idx = (i inside {2, 3, 4}) ? SPD_300 : ((i inside {5, 6}) ? SPD_1200 : 5'h07);
      link.reliable = rl[i];
      report_mod = rm[i];
      conn_evt_valid = 1'b1;
      cyc(1);
      conn_evt_valid = 1'b0;
      chk(conn_valid === 1'b1 && conn_rpt.tag === tg[i], "connect tag");
      chk(conn_rpt.speed_idx === link.speed_idx, "connect speed");
      if (!(i inside {4, 5, 6})) chk(conn_rpt.rel_sfx === rl[i], "suffix");
      cyc(1);
    end
    link = OK_LINK;
  endtask

  task automatic test_done();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    errors++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    {cmd_valid, dur_wr, rmt_req_valid, call_evt_valid, conn_evt_valid} = '0;
    {report_mod, host_tx_valid, echo_en, stall, corrupt} = '0;
    host_rx_ready = 1'b1;
    cmd = CMD_NONE;
    dur_wdata = 8'h00;
    host_tx_data = 8'h00;
    call_evt_code = 4'h0;
    cp_sel = 3'h1;
    link = OK_LINK;
    errors = 0;
    n_tests = 0;
    drops = 0;
    cyc(10);
    nrst = 1'b1;
    cyc(2);
    chk(test_duration_seconds === DUR_RST, "duration reset");
    t_refuse();
    t_local();
    t_remote();
    t_self();
    t_rmt_req();
    t_codes();
    t_conn();
    test_done();
  end
endmodule

/* File: test/mlb_remote_model.sv */
// Purpose: Behavioural remote modem on the far side of the line
// Assumes: Driven at the falling edge, sampled at the rising edge
// Notes: Echo, stall and single-bit corruption are bench controlled
`timescale 1ns/1ps

module mlb_remote_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic echo_en,
  input wire logic stall,
  input wire logic corrupt,
  input wire logic line_tx_valid,
  input wire logic [7:0] line_tx_data,
  output logic line_tx_ready,
  output logic line_rx_valid,
  output logic [7:0] line_rx_data,
  input wire logic line_rx_ready
);
  logic [7:0] q[$];
  logic [7:0] seen[$];
  logic [7:0] last;
  task automatic send(input logic [7:0] d);
    q.push_back(d);
  endtask
  initial begin
    line_tx_ready = 1'b0;
    line_rx_valid = 1'b0;
    line_rx_data = 8'h00;
    last = 8'h00;
  end
  always @(posedge sys_clk) begin
    if (line_rx_valid === 1'b1 && line_rx_ready === 1'b1) begin
      last = q.pop_front();
    end
    if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) begin
      seen.push_back(line_tx_data);
      if (echo_en) begin
        q.push_back(line_tx_data ^ {7'h00, corrupt});
      end
    end
  end
  // Idle data shows the inverse of the last word
  always @(negedge sys_clk) begin
    line_tx_ready <= nrst && !stall;
    line_rx_valid <= nrst && (q.size() > 0);
    line_rx_data <= (q.size() > 0) ? q[0] : ~last;
  end
endmodule
